// [rfs_radio_ctrl.sv]
`timescale 1ns/100ps
// Notes on behaviour
// - pending interrupt drives the active-low interrupt pin low.
// - any enabled event occurring asserts the interrupt pin.
// - pin stays low until the status register holding the bit is read.
// - after that read the pin releases until a new status change.
// - only events with their enable bit set drive the pin.
// - reading a status register clears its enabled bits.
// - disabled events still latch status, readable any time, no pin effect.
// - host writes only the mode; sequencer does the transition steps.
// - VCO calibrates on every frequency change and synth power-up.
// - synthesizer settle wait defaults to 100 us.
// - bias settle, calibration and settle total 200 us.
// - third-order modulator, modulo 64000 accumulators, 10 MHz rate.
// - fraction built from carrier fraction, offset and deviation words.
// - frequency-shift modulation varies the fraction with transmit data.
// - integer is band field plus 24; carrier from band, integer, fraction.
// - band-high bit selects output divide-by-two, low band is half.
// - band field holds 0 to 23; larger writes become 23.
// - receive mode lowers synthesizer by 937.5 kHz, registers untouched.
// - receive and transmit on one channel need no reprogramming.
module rfs_radio_ctrl
	import rfs_pkg::*;
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// register port
	input wire logic [6:0] REG_ADDR,
	input wire logic REG_WE,
	input wire logic REG_RE,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	// interrupt events and pin
	input wire logic [7:0] EVENT_FIRST,
	input wire logic [7:0] EVENT_SECOND,
	output logic RADIO_INTERRUPT_OUT_LOW,
	// mode and modulation from the operating-mode logic
	input wire logic SYNTH_ON,
	input wire logic RX_MODE,
	input wire logic TX_DATA,
	input wire logic [7:0] DEVIATION_WORD,
	// synthesizer controls
	output logic [6:0] DIV_VALUE,
	output logic HIGH_BAND,
	output logic VCO_CAL_ACTIVE,
	output logic SYNTH_READY
);

	typedef struct packed {
		logic [7:0] stat1;
		logic [7:0] stat2;
		logic [7:0] en1;
		logic [7:0] en2;
		logic [7:0] fo_lo;
		logic [1:0] fo_hi;
		logic sbsel;
		logic hbsel;
		logic [4:0] fb;
		logic [7:0] fc_hi;
		logic [7:0] fc_lo;
		logic [7:0] rdata;
		logic irq_n;
		rfs_seq_e seq;
		logic [10:0] cnt;
		logic [12:0] seq_cyc;
		logic synth_on_prev;
		logic [6:0] n_int;
		logic [15:0] frac;
		logic [6:0] div;
	} rfs_state_s;

	rfs_state_s s_q, s_d;
	logic signed [3:0] dsm_corr;
	logic rd_stat1, rd_stat2, freq_wr;
	logic [6:0] n_base;
	logic signed [17:0] fo_ext, dev, if_shift, frac_s;
	logic [7:0] keep1;

	rfs_dsm #(
		.MODULUS(DSM_MODULUS),
		.CLK_DIV(DSM_CLK_DIV)
	) u_dsm (
		.ref_clk(REF_CLK),
		.nrst(NRST),
		.frac(s_q.frac),
		.corr(dsm_corr)
	);

	always_comb begin
		s_d = s_q;
		rd_stat1 = REG_RE && REG_ADDR == ADDR_IRQ_STATUS_FIRST;
		rd_stat2 = REG_RE && REG_ADDR == ADDR_IRQ_STATUS_SECOND;
		freq_wr = REG_WE && REG_ADDR >= ADDR_FREQ_OFFSET_LOW &&
			REG_ADDR <= ADDR_CARRIER_FRACTION_LOW;

		// status latch; an event in the read cycle survives the clear
		s_d.stat1 = s_q.stat1 | EVENT_FIRST;
		s_d.stat2 = s_q.stat2 | EVENT_SECOND;
		if (rd_stat1)
			s_d.stat1 = (s_q.stat1 & ~s_q.en1) | EVENT_FIRST;
		if (rd_stat2)
			s_d.stat2 = (s_q.stat2 & ~s_q.en2) | EVENT_SECOND;

		if (REG_RE) begin
			unique case (REG_ADDR)
				ADDR_IRQ_STATUS_FIRST: s_d.rdata = s_q.stat1;
				ADDR_IRQ_STATUS_SECOND: s_d.rdata = s_q.stat2;
				ADDR_IRQ_ENABLE_FIRST: s_d.rdata = s_q.en1;
				ADDR_IRQ_ENABLE_SECOND: s_d.rdata = s_q.en2;
				ADDR_FREQ_OFFSET_LOW: s_d.rdata = s_q.fo_lo;
				ADDR_FREQ_OFFSET_HIGH: s_d.rdata = {6'h00, s_q.fo_hi};
				ADDR_BAND_SELECT: s_d.rdata = {1'b0, s_q.sbsel, s_q.hbsel, s_q.fb};
				ADDR_CARRIER_FRACTION_HIGH: s_d.rdata = s_q.fc_hi;
				ADDR_CARRIER_FRACTION_LOW: s_d.rdata = s_q.fc_lo;
				default: s_d.rdata = 8'h00;
			endcase
		end

		if (REG_WE) begin
			unique case (REG_ADDR)
				ADDR_IRQ_ENABLE_FIRST: s_d.en1 = REG_WDATA;
				ADDR_IRQ_ENABLE_SECOND: s_d.en2 = REG_WDATA;
				ADDR_FREQ_OFFSET_LOW: s_d.fo_lo = REG_WDATA;
				ADDR_FREQ_OFFSET_HIGH:
					s_d.fo_hi = REG_WDATA[FREQ_OFFSET_HIGH_MSB:0];
				ADDR_BAND_SELECT: begin
					s_d.sbsel = REG_WDATA[BAND_SBSEL_BIT];
					s_d.hbsel = REG_WDATA[BAND_HBSEL_BIT];
					if (REG_WDATA[BAND_FIELD_MSB:0] > BAND_INTEGER_MAX)
						s_d.fb = BAND_INTEGER_MAX;
					else
						s_d.fb = REG_WDATA[BAND_FIELD_MSB:0];
				end
				ADDR_CARRIER_FRACTION_HIGH: s_d.fc_hi = REG_WDATA;
				ADDR_CARRIER_FRACTION_LOW: s_d.fc_lo = REG_WDATA;
				default: ;
			endcase
		end

		// pin follows the enabled latched bits of the next state
		s_d.irq_n = ~|({s_d.stat1, s_d.stat2} & {s_d.en1, s_d.en2});

		// calibration sequence, restarted by power-up or any retune
		s_d.synth_on_prev = SYNTH_ON;
		if (s_q.seq != SEQ_LOCKED && s_q.seq != SEQ_OFF)
			s_d.seq_cyc = 13'(s_q.seq_cyc + 13'h0001);
		if (!SYNTH_ON) begin
			s_d.seq = SEQ_OFF;
		end else if (freq_wr || !s_q.synth_on_prev || s_q.seq == SEQ_OFF) begin
			s_d.seq = SEQ_BIAS;
			s_d.cnt = 11'(BIAS_CYC - 1);
			s_d.seq_cyc = 13'h0001;
		end else begin
			unique case (s_q.seq)
				SEQ_BIAS: begin
					if (s_q.cnt == 11'h000) begin
						s_d.seq = SEQ_CAL;
						s_d.cnt = 11'(CAL_CYC - 1);
					end else
						s_d.cnt = 11'(s_q.cnt - 11'h001);
				end
				SEQ_CAL: begin
					if (s_q.cnt == 11'h000) begin
						s_d.seq = SEQ_SETTLE;
						s_d.cnt = 11'(SETTLE_CYC - 1);
					end else
						s_d.cnt = 11'(s_q.cnt - 11'h001);
				end
				SEQ_SETTLE: begin
					if (s_q.cnt == 11'h000)
						s_d.seq = SEQ_LOCKED;
					else
						s_d.cnt = 11'(s_q.cnt - 11'h001);
				end
				SEQ_LOCKED: ;
				default: s_d.seq = SEQ_OFF;
			endcase
		end

		// division ratio; all corrections in fraction units of the band
		n_base = 7'({2'b00, s_q.fb} + BAND_INTEGER_OFFSET);
		fo_ext = 18'($signed({s_q.fo_hi, s_q.fo_lo}));
		if (RX_MODE)
			dev = 18'sh00000;
		else if (s_q.hbsel)
			dev = $signed({9'h000, DEVIATION_WORD, 1'b0});
		else
			dev = $signed({8'h00, DEVIATION_WORD, 2'b00});
		if (!RX_MODE && !TX_DATA)
			dev = 18'(-dev);
		// low-side injection: the same words serve receive and transmit
		if (!RX_MODE)
			if_shift = 18'sh00000;
		else if (s_q.hbsel)
			if_shift = RX_IF_SHIFT_HIGH_BAND;
		else
			if_shift = RX_IF_SHIFT_LOW_BAND;
		frac_s = 18'($signed({2'b00, s_q.fc_hi, s_q.fc_lo}) + fo_ext + dev -
			if_shift);
		// the offsets are far below the modulus, so one wrap is enough
		if (frac_s < 18'sh00000) begin
			s_d.frac = 16'(frac_s + 18'(DSM_MODULUS));
			s_d.n_int = 7'(n_base - 7'h01);
		end else if (frac_s >= 18'(DSM_MODULUS)) begin
			s_d.frac = 16'(frac_s - 18'(DSM_MODULUS));
			s_d.n_int = 7'(n_base + 7'h01);
		end else begin
			s_d.frac = frac_s[15:0];
			s_d.n_int = n_base;
		end
		s_d.div = 7'(s_q.n_int + {{3{dsm_corr[3]}}, dsm_corr});
	end

	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			s_q <= '0;
			s_q.en1 <= RST_IRQ_ENABLE_FIRST;
			s_q.en2 <= RST_IRQ_ENABLE_SECOND;
			s_q.stat1 <= RST_IRQ_STATUS;
			s_q.stat2 <= RST_IRQ_STATUS;
			s_q.fo_lo <= RST_FREQ_OFFSET_LOW;
			s_q.fo_hi <= RST_FREQ_OFFSET_HIGH[FREQ_OFFSET_HIGH_MSB:0];
			s_q.sbsel <= RST_BAND_SELECT[BAND_SBSEL_BIT];
			s_q.hbsel <= RST_BAND_SELECT[BAND_HBSEL_BIT];
			s_q.fb <= RST_BAND_SELECT[BAND_FIELD_MSB:0];
			s_q.fc_hi <= RST_CARRIER_FRACTION_HIGH;
			s_q.fc_lo <= RST_CARRIER_FRACTION_LOW;
			s_q.irq_n <= 1'b1;
			s_q.seq <= SEQ_OFF;
		end else
			s_q <= s_d;
	end

	assign REG_RDATA = s_q.rdata;
	assign RADIO_INTERRUPT_OUT_LOW = s_q.irq_n;
	assign DIV_VALUE = s_q.div;
	assign HIGH_BAND = s_q.hbsel;
	assign VCO_CAL_ACTIVE = s_q.seq == SEQ_CAL;
	assign SYNTH_READY = s_q.seq == SEQ_LOCKED;
	assign keep1 = s_q.stat1 & ~s_q.en1;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);

	property p_event_pulls_low;
		(|(EVENT_FIRST & s_q.en1) || |(EVENT_SECOND & s_q.en2)) && !REG_WE
			|=> !RADIO_INTERRUPT_OUT_LOW;
	endproperty
	a_event_pulls_low: assert property (p_event_pulls_low)
		else $error("enabled event did not pull the interrupt low");

	property p_low_until_read;
		!RADIO_INTERRUPT_OUT_LOW && !REG_RE && !REG_WE
			|=> !RADIO_INTERRUPT_OUT_LOW;
	endproperty
	a_low_until_read: assert property (p_low_until_read)
		else $error("interrupt released without a status read");

	property p_read_clears;
		REG_RE && REG_ADDR == ADDR_IRQ_STATUS_FIRST && EVENT_FIRST == 8'h00
			|=> (s_q.stat1 & s_q.en1) == 8'h00;
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("status read left enabled bits set");

	property p_release_after_read;
		REG_RE && REG_ADDR == ADDR_IRQ_STATUS_FIRST && !REG_WE &&
			EVENT_FIRST == 8'h00 && EVENT_SECOND == 8'h00 &&
			(s_q.stat2 & s_q.en2) == 8'h00
			|=> RADIO_INTERRUPT_OUT_LOW ##1 (RADIO_INTERRUPT_OUT_LOW ||
			$past(EVENT_FIRST) != 8'h00 || $past(EVENT_SECOND) != 8'h00 ||
			$past(REG_WE));
	endproperty
	a_release_after_read: assert property (p_release_after_read)
		else $error("interrupt not released after status read");

	property p_disabled_kept;
		REG_RE && REG_ADDR == ADDR_IRQ_STATUS_FIRST
			|=> (s_q.stat1 & $past(keep1)) == $past(keep1);
	endproperty
	a_disabled_kept: assert property (p_disabled_kept)
		else $error("disabled status bit lost on read");

	property p_band_clamp;
		REG_WE && REG_ADDR == ADDR_BAND_SELECT &&
			REG_WDATA[BAND_FIELD_MSB:0] > BAND_INTEGER_MAX
			|=> s_q.fb == BAND_INTEGER_MAX;
	endproperty
	a_band_clamp: assert property (p_band_clamp)
		else $error("band field not clamped to its maximum");

	property p_retune_calibrates;
		SYNTH_ON && freq_wr ##1 (SYNTH_ON && !freq_wr) [*8]
			|-> s_q.seq == SEQ_BIAS && !SYNTH_READY;
	endproperty
	a_retune_calibrates: assert property (p_retune_calibrates)
		else $error("frequency change did not restart calibration");

	property p_total_time;
		// the count steps once more on the edge that locks
		$rose(SYNTH_READY) |-> $past(s_q.seq_cyc) == 13'(TOTAL_CYC);
	endproperty
	a_total_time: assert property (p_total_time)
		else $error("settling sequence length wrong");

endmodule

// [rfs_pkg.sv]
package rfs_pkg;

	// register offsets
	localparam logic [6:0] ADDR_IRQ_STATUS_FIRST = 7'h03;
	localparam logic [6:0] ADDR_IRQ_STATUS_SECOND = 7'h04;
	localparam logic [6:0] ADDR_IRQ_ENABLE_FIRST = 7'h05;
	localparam logic [6:0] ADDR_IRQ_ENABLE_SECOND = 7'h06;
	localparam logic [6:0] ADDR_FREQ_OFFSET_LOW = 7'h73;
	localparam logic [6:0] ADDR_FREQ_OFFSET_HIGH = 7'h74;
	localparam logic [6:0] ADDR_BAND_SELECT = 7'h75;
	localparam logic [6:0] ADDR_CARRIER_FRACTION_HIGH = 7'h76;
	localparam logic [6:0] ADDR_CARRIER_FRACTION_LOW = 7'h77;

	// reset values
	localparam logic [7:0] RST_IRQ_STATUS = 8'h00;
	localparam logic [7:0] RST_IRQ_ENABLE_FIRST = 8'h00;
	localparam logic [7:0] RST_IRQ_ENABLE_SECOND = 8'h01;
	localparam logic [7:0] RST_FREQ_OFFSET_LOW = 8'h00;
	localparam logic [7:0] RST_FREQ_OFFSET_HIGH = 8'h00;
	localparam logic [7:0] RST_BAND_SELECT = 8'h35;
	localparam logic [7:0] RST_CARRIER_FRACTION_HIGH = 8'hBB;
	localparam logic [7:0] RST_CARRIER_FRACTION_LOW = 8'h80;

	// band select and frequency offset high field positions
	localparam int BAND_SBSEL_BIT = 6;
	localparam int BAND_HBSEL_BIT = 5;
	localparam int BAND_FIELD_MSB = 4;
	localparam int FREQ_OFFSET_HIGH_MSB = 1;

	// synthesizer arithmetic
	localparam logic [4:0] BAND_INTEGER_MAX = 5'h17;
	localparam logic [6:0] BAND_INTEGER_OFFSET = 7'h18;
	localparam int DSM_MODULUS = 64000;
	localparam logic signed [17:0] RX_IF_SHIFT_LOW_BAND = 18'sh01770;
	localparam logic signed [17:0] RX_IF_SHIFT_HIGH_BAND = 18'sh00BB8;
	localparam int DSM_CLK_DIV = 2;

	// sequencer timing
	localparam int unsigned REF_CLK_PERIOD_NS = 50;
	localparam int unsigned VCO_BIAS_SETTLE_US = 50;
	localparam int unsigned SYNTH_SETTLE_US = 100;
	localparam int unsigned SYNTH_TOTAL_US = 200;
	localparam int unsigned BIAS_CYC =
		(VCO_BIAS_SETTLE_US * 1000 + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
	localparam int unsigned SETTLE_CYC =
		(SYNTH_SETTLE_US * 1000 + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
	localparam int unsigned TOTAL_CYC =
		(SYNTH_TOTAL_US * 1000) / REF_CLK_PERIOD_NS;
	localparam int unsigned CAL_CYC = TOTAL_CYC - BIAS_CYC - SETTLE_CYC;

	typedef enum logic [2:0] {
		SEQ_OFF,
		SEQ_BIAS,
		SEQ_CAL,
		SEQ_SETTLE,
		SEQ_LOCKED
	} rfs_seq_e;

endpackage

// [rfs_dsm.sv]
`timescale 1ns/100ps
module rfs_dsm
	import rfs_pkg::*;
#(
	parameter int MODULUS = DSM_MODULUS,
	parameter int CLK_DIV = DSM_CLK_DIV
)(
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// fraction in, integer correction out
	input wire logic [15:0] frac,
	output logic signed [3:0] corr
);

	if (MODULUS < 2 || MODULUS > 65536 || CLK_DIV != 2) begin : g_chk
		$error("rfs_dsm: unsupported modulus or clock divide");
	end

	typedef struct packed {
		logic phase;
		logic [15:0] acc1;
		logic [15:0] acc2;
		logic [15:0] acc3;
		logic c1_d1;
		logic c1_d2;
		logic c2_d1;
		logic c2_d2;
		logic c3_d1;
		logic c3_d2;
		logic signed [3:0] corr;
	} rfs_dsm_s;

	rfs_dsm_s s_q, s_d;

	// add with wrap at the modulus, carry on top
	function automatic logic [16:0] mod_add(input logic [15:0] a,
		input logic [15:0] b);
		logic [16:0] sum;
		sum = {1'b0, a} + {1'b0, b};
		if (sum >= 17'(MODULUS))
			return {1'b1, 16'(sum - 17'(MODULUS))};
		return {1'b0, sum[15:0]};
	endfunction

	logic [16:0] r1, r2, r3;

	always_comb begin
		r1 = mod_add(s_q.acc1, frac);
		r2 = mod_add(s_q.acc2, r1[15:0]);
		r3 = mod_add(s_q.acc3, r2[15:0]);
		s_d = s_q;
		s_d.phase = ~s_q.phase;
		// modulator steps at half the reference clock, the 10 MHz rate
		if (s_q.phase) begin
			s_d.acc1 = r1[15:0];
			s_d.acc2 = r2[15:0];
			s_d.acc3 = r3[15:0];
			s_d.c1_d1 = r1[16];
			s_d.c1_d2 = s_q.c1_d1;
			s_d.c2_d1 = r2[16];
			s_d.c2_d2 = s_q.c2_d1;
			s_d.c3_d1 = r3[16];
			s_d.c3_d2 = s_q.c3_d1;
			// third-order noise shaping of the three carries
			s_d.corr = 4'($signed({3'b000, s_q.c1_d2}) +
				$signed({3'b000, s_q.c2_d1}) - $signed({3'b000, s_q.c2_d2}) +
				$signed({3'b000, r3[16]}) - $signed({2'b00, s_q.c3_d1, 1'b0}) +
				$signed({3'b000, s_q.c3_d1}) - $signed({3'b000, s_q.c3_d1}) +
				$signed({3'b000, s_q.c3_d2}));
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign corr = s_q.corr;

endmodule

// [rfs_host_model.sv]
`timescale 1ns/100ps
module rfs_host_model
	import rfs_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// register port
	output logic [6:0] reg_addr,
	output logic reg_we,
	output logic reg_re,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// mode request and interrupt line
	output logic synth_on,
	output logic rx_mode,
	input wire logic radio_interrupt_out_low
);
	int irq_count = 0;

	initial begin
		reg_addr = 7'h00;
		reg_we = 1'b0;
		reg_re = 1'b0;
		reg_wdata = 8'h00;
		synth_on = 1'b0;
		rx_mode = 1'b0;
	end

	// pin looped to an edge-triggered host input, no vector inside the radio
	always @(negedge radio_interrupt_out_low) begin
		irq_count++;
	end

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge ref_clk);
		reg_we <= 1'b0;
		// released data shows no stale value
		reg_wdata <= ~d;
	endtask

	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge ref_clk);
		reg_re <= 1'b0;
		@(posedge ref_clk);
		#1;
		d = reg_rdata;
	endtask

	// the host only asks for a mode; the steps are the device's job
	task automatic set_mode(input logic on, input logic rx);
		@(posedge ref_clk);
		synth_on <= on;
		rx_mode <= rx;
	endtask
endmodule

// [tb.sv]
`timescale 1ns/100ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module tb
	import rfs_pkg::*;
;
	typedef struct {
		logic [6:0] a;
		logic [7:0] w;
		logic [7:0] rst;
		logic [7:0] rb;
	} rfs_row_s;

	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] ev1 = 8'h00;
	logic [7:0] ev2 = 8'h00;
	logic tx_data = 1'b0;
	logic [7:0] dev = 8'hFF;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [6:0] div_value;
	logic we, re, synth_on, rx_mode, irq_n, high_band, cal_act, ready;
	int fails = 0;
	int comparisons = 0;
	rfs_row_s rows [10] = '{
		'{7'h05, 8'hF4, 8'h00, 8'hF4}, '{7'h06, 8'h81, 8'h01, 8'h81},
		'{7'h73, 8'hA5, 8'h00, 8'hA5}, '{7'h74, 8'hFF, 8'h00, 8'h03},
		'{7'h75, 8'hFF, 8'h35, 8'h77}, '{7'h76, 8'h12, 8'hBB, 8'h12},
		'{7'h77, 8'h34, 8'h80, 8'h34}, '{7'h03, 8'hFF, 8'h00, 8'h00},
		'{7'h59, 8'h03, 8'h00, 8'h00}, '{7'h5A, 8'h02, 8'h00, 8'h00}};
	logic rxv [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
	logic txv [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
	logic [9:0] fov [5] = '{10'h000, 10'h000, 10'h000, 10'h338, 10'h000};
	logic [7:0] bsv [5] = '{8'h20, 8'h20, 8'h20, 8'h20, 8'h00};
	int fexp [5] = '{32510, 31490, 29000, 32310, 26000};

	initial begin
		forever #25 ref_clk = ~ref_clk;
	end

	rfs_radio_ctrl dut (
		.REF_CLK(ref_clk), .NRST(nrst), .REG_ADDR(addr), .REG_WE(we),
		.REG_RE(re), .REG_WDATA(wdata), .REG_RDATA(rdata),
		.EVENT_FIRST(ev1), .EVENT_SECOND(ev2),
		.RADIO_INTERRUPT_OUT_LOW(irq_n), .SYNTH_ON(synth_on),
		.RX_MODE(rx_mode), .TX_DATA(tx_data), .DEVIATION_WORD(dev),
		.DIV_VALUE(div_value), .HIGH_BAND(high_band),
		.VCO_CAL_ACTIVE(cal_act), .SYNTH_READY(ready));

	rfs_host_model host (
		.ref_clk(ref_clk), .reg_addr(addr), .reg_we(we), .reg_re(re),
		.reg_wdata(wdata), .reg_rdata(rdata), .synth_on(synth_on),
		.rx_mode(rx_mode), .radio_interrupt_out_low(irq_n));

	task automatic chk(input string n, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("FAIL %s expected %0h seen %0h", n, e, g);
		end
	endtask

	task automatic end_sim;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic pulse(input logic [7:0] a, input logic [7:0] b);
		@(posedge ref_clk);
		ev1 <= a;
		ev2 <= b;
		@(posedge ref_clk);
		ev1 <= 8'h00;
		ev2 <= 8'h00;
		tick(3);
	endtask

	// cycles to ready, cycles in calibration, cycles from calibration to ready
	task automatic seq(output int t, output int c, output int s);
		int last;
		t = 0;
		c = 0;
		last = 0;
		while (ready !== 1'b1 && t < 6000) begin
			@(posedge ref_clk);
			#1;
			t++;
			if (cal_act === 1'b1) begin
				c++;
				last = t;
			end
		end
		s = t - last;
	endtask

	initial begin
		logic [7:0] d;
		int t, c, s, sm, e;
		repeat (10) @(posedge ref_clk);
		`CHK("pin in reset", 1'b1, irq_n);
		`CHK("ready in reset", 1'b0, ready);
		nrst <= 1'b1;
		foreach (rows[i]) begin
			host.rd(rows[i].a, d);
			`CHK("reset value", rows[i].rst, d);
			host.wr(rows[i].a, rows[i].w);
			host.rd(rows[i].a, d);
			`CHK("readback", rows[i].rb, d);
		end
		`CHK("high band", 1'b1, high_band);
		host.wr(ADDR_BAND_SELECT, 8'h00);
		tick(2);
		`CHK("low band", 1'b0, high_band);
		$display("test registers done");
		host.wr(ADDR_IRQ_ENABLE_FIRST, 8'h04);
		pulse(8'h08, 8'h00);
		`CHK("pin after masked event", 1'b1, irq_n);
		pulse(8'h04, 8'h00);
		`CHK("pin after event", 1'b0, irq_n);
		tick(20);
		host.rd(ADDR_IRQ_STATUS_SECOND, d);
		`CHK("pin after other read", 1'b0, irq_n);
		host.rd(ADDR_IRQ_STATUS_FIRST, d);
		`CHK("status first", 8'h0C, d);
		tick(2);
		`CHK("pin after read", 1'b1, irq_n);
		host.rd(ADDR_IRQ_STATUS_FIRST, d);
		`CHK("masked bit kept", 8'h08, d);
		pulse(8'h00, 8'h01);
		`CHK("pin second event", 1'b0, irq_n);
		host.rd(ADDR_IRQ_STATUS_SECOND, d);
		`CHK("status second", 8'h01, d);
		tick(2);
		`CHK("pin second read", 1'b1, irq_n);
		`CHK("host interrupt count", 2, host.irq_count);
		$display("test interrupts done");
		host.wr(ADDR_BAND_SELECT, 8'h20);
		host.wr(ADDR_CARRIER_FRACTION_HIGH, 8'h7D);
		host.wr(ADDR_CARRIER_FRACTION_LOW, 8'h00);
		host.set_mode(1'b1, 1'b0);
		seq(t, c, s);
		`CHK("total", t >= TOTAL_CYC && t <= TOTAL_CYC + 4, 1'b1);
		`CHK("calibration", CAL_CYC, c);
		`CHK("settle", s >= SETTLE_CYC && s <= SETTLE_CYC + 1, 1'b1);
		host.wr(ADDR_CARRIER_FRACTION_LOW, 8'h00);
		tick(2);
		`CHK("ready on retune", 1'b0, ready);
		seq(t, c, s);
		`CHK("recalibration", CAL_CYC, c);
		$display("test sequencer done");
		for (int i = 0; i < 5; i++) begin
			host.set_mode(1'b1, rxv[i]);
			@(posedge ref_clk);
			tx_data <= txv[i];
			host.wr(ADDR_BAND_SELECT, bsv[i]);
			host.wr(ADDR_FREQ_OFFSET_LOW, fov[i][7:0]);
			host.wr(ADDR_FREQ_OFFSET_HIGH, {6'h00, fov[i][9:8]});
			seq(t, c, s);
			tick(20);
			sm = 0;
			repeat (8000) begin
				@(posedge ref_clk);
				#1;
				sm += int'(div_value);
			end
			// mean over 8000 cycles, N = 24, with slack for modulator noise
			e = sm * 8 - 1536000 - fexp[i];
			`CHK("mean division", e <= 128 && e >= -128, 1'b1);
		end
		host.set_mode(1'b0, 1'b0);
		tick(2);
		`CHK("ready off", 1'b0, ready);
		$display("test synthesizer done");
		pulse(8'h04, 8'h00);
		`CHK("pin before reset", 1'b0, irq_n);
		@(posedge ref_clk);
		nrst <= 1'b0;
		tick(3);
		`CHK("pin in mid reset", 1'b1, irq_n);
		@(posedge ref_clk);
		nrst <= 1'b1;
		host.rd(ADDR_IRQ_STATUS_FIRST, d);
		`CHK("status after reset", 8'h00, d);
		host.rd(ADDR_IRQ_ENABLE_SECOND, d);
		`CHK("enable after reset", 8'h01, d);
		$display("test reset done");
		end_sim;
	end

	initial begin
		repeat (95000) @(posedge ref_clk);
		fails++;
		$display("FAIL watchdog expected finish seen timeout");
		end_sim;
	end
endmodule
